/* File: snd_consts.svh */
`ifndef SND_CONSTS_SVH
`define SND_CONSTS_SVH

// data buffer geometry
`define SND_BUF_BYTES 2112
`define SND_BUF_LAST 12'h83F

// instruction codes handled by this block
`define SND_CMD_DIO4 8'hBC
`define SND_CMD_QIO 8'hEB
`define SND_CMD_QIO4 8'hEC
`define SND_CMD_DTR 8'h0D
`define SND_CMD_DTR4 8'h0E
`define SND_CMD_DTR_DUAL 8'h3D
`define SND_CMD_DTR_QUAD 8'h6D

// serial clocks after the instruction (address plus dummy), per read mode
`define SND_PRE_DTR_B1 6'd24
`define SND_PRE_DTR_B0 6'd32
`define SND_PRE_DTR4_B1 6'd40
`define SND_PRE_DTR4_B0 6'd56
`define SND_PRE_DIO4_B1 6'd20
`define SND_PRE_DIO4_B0 6'd28
`define SND_PRE_QIO_B1 6'd8
`define SND_PRE_QIO_B0 6'd12
`define SND_PRE_QIO4_B1 6'd14
`define SND_PRE_QIO4_B0 6'd14

// column address width on the wire
`define SND_COL_BITS 5'd16

`endif

/* File: snd_pkg.sv */
package snd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_PRE = 3'h3,
    ST_DATA = 3'h2,
    ST_HIZ = 3'h6
  } snd_state_t;

  typedef enum logic [1:0] {
    LW_ONE = 2'h0,
    LW_TWO = 2'h1,
    LW_FOUR = 2'h2
  } snd_width_t;

endpackage : snd_pkg

/* File: snd_buf_mem.sv */
`timescale 1ns/1ps
`include "snd_consts.svh"
module snd_buf_mem (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [11:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [11:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:`SND_BUF_BYTES-1];

  // writes beyond the last byte are dropped
  always_ff @(posedge clk) begin
    if (wr_en && wr_addr <= `SND_BUF_LAST) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_addr <= `SND_BUF_LAST) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= 8'hFF;
    end
  end
endmodule : snd_buf_mem

/* File: snd_read_seq.sv */
`timescale 1ns/1ps
`include "snd_consts.svh"
module snd_read_seq import snd_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe,
  input wire logic four_lane_enable,
  input wire logic prot_mode,
  input wire logic buf_mode,
  input wire logic load_we,
  input wire logic [11:0] load_addr,
  input wire logic [7:0] load_data,
  output logic page_next
);
  logic sclk_s1, sclk_s2, sclk_s3, cs_n_s1, cs_n_s2;
  logic [3:0] lane_s1, lane_s2;
  snd_state_t state_reg;
  logic [6:0] cmd_reg;
  logic [2:0] bit_cnt_reg;
  logic [5:0] pre_cnt_reg, pre_last_reg;
  logic [4:0] addr_clk_reg;
  logic [15:0] addr_reg;
  snd_width_t in_w_reg, out_w_reg;
  logic dtr_reg, buf_reg;
  logic [11:0] rd_addr_reg;
  logic [7:0] byte_reg, mem_dout, cur_byte;
  logic [2:0] beat_reg, beat_mask;
  logic end_reg, page_next_reg;
  logic [3:0] lane_out_reg, lane_oe_reg;
  logic [7:0] cmd_byte;
  logic known, quad_cmd, dtr_cmd;
  snd_width_t in_w, out_w;
  logic [5:0] pre_total;
  logic sclk_rise, sclk_fall, cs_hi, cmd_done, pre_done, beat;

  // pin synchronisers; the second stage is looked at, and sclk edges also use its third stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {sclk_s3, sclk_s2, sclk_s1} <= 3'h0;
      {cs_n_s2, cs_n_s1} <= 2'h3;
      {lane_s2, lane_s1} <= 8'h00;
    end else begin
      {sclk_s3, sclk_s2, sclk_s1} <= {sclk_s2, sclk_s1, sclk};
      {cs_n_s2, cs_n_s1} <= {cs_n_s1, cs_n};
      {lane_s2, lane_s1} <= {lane_s1, lane_in};
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign cs_hi = cs_n_s2;
  assign cmd_byte = {cmd_reg, lane_s2[0]};
  assign cmd_done = (state_reg == ST_CMD) && sclk_rise && (bit_cnt_reg == 3'h7);
  assign pre_done = (state_reg == ST_PRE) && sclk_rise && (pre_cnt_reg == pre_last_reg);
  // single-rate reads shift out on falling edges only; a deselect wins over a last edge
  assign beat = (state_reg == ST_DATA) && !cs_hi && (sclk_fall || (dtr_reg && sclk_rise));

  always_comb begin
    known = 1'b1;
    quad_cmd = 1'b0;
    dtr_cmd = 1'b1;
    in_w = LW_ONE;
    out_w = LW_ONE;
    pre_total = buf_mode ? `SND_PRE_DTR_B1 : `SND_PRE_DTR_B0;
    unique case (cmd_byte)
      `SND_CMD_DIO4: begin
        dtr_cmd = 1'b0;
        in_w = LW_TWO;
        out_w = LW_TWO;
        pre_total = buf_mode ? `SND_PRE_DIO4_B1 : `SND_PRE_DIO4_B0;
      end
      `SND_CMD_QIO, `SND_CMD_QIO4: begin
        dtr_cmd = 1'b0;
        quad_cmd = 1'b1;
        in_w = LW_FOUR;
        out_w = LW_FOUR;
        if (cmd_byte == `SND_CMD_QIO4) begin
          pre_total = buf_mode ? `SND_PRE_QIO4_B1 : `SND_PRE_QIO4_B0;
        end else begin
          pre_total = buf_mode ? `SND_PRE_QIO_B1 : `SND_PRE_QIO_B0;
        end
      end
      `SND_CMD_DTR: out_w = LW_ONE;
      `SND_CMD_DTR4: pre_total = buf_mode ? `SND_PRE_DTR4_B1 : `SND_PRE_DTR4_B0;
      `SND_CMD_DTR_DUAL: out_w = LW_TWO;
      `SND_CMD_DTR_QUAD: begin
        quad_cmd = 1'b1;
        out_w = LW_FOUR;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // command framing; deselect always returns to idle
  always_ff @(posedge clk) begin
    if (sys_rst || cs_hi) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 7'h0;
      bit_cnt_reg <= 3'h0;
      pre_cnt_reg <= 6'h0;
      pre_last_reg <= 6'h0;
      addr_clk_reg <= 5'h0;
      addr_reg <= 16'h0;
      in_w_reg <= LW_ONE;
      out_w_reg <= LW_ONE;
      dtr_reg <= 1'b0;
      buf_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: state_reg <= ST_CMD;
        ST_CMD: begin
          if (sclk_rise) begin
            cmd_reg <= cmd_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
          if (cmd_done) begin
            if (!known || (quad_cmd && (!four_lane_enable || prot_mode))) begin
              state_reg <= ST_HIZ;
            end else begin
              state_reg <= ST_PRE;
            end
            pre_last_reg <= pre_total - 6'd1;
            // quad 4-byte continuous read carries dummy clocks only
            if (cmd_byte == `SND_CMD_QIO4 && !buf_mode) begin
              addr_clk_reg <= 5'h0;
            end else begin
              addr_clk_reg <= `SND_COL_BITS >> in_w;
            end
            in_w_reg <= in_w;
            out_w_reg <= out_w;
            dtr_reg <= dtr_cmd;
            buf_reg <= buf_mode;
          end
        end
        ST_PRE: begin
          if (sclk_rise) begin
            pre_cnt_reg <= pre_cnt_reg + 6'd1;
            if (pre_cnt_reg < {1'b0, addr_clk_reg}) begin
              unique case (in_w_reg)
                LW_ONE: addr_reg <= {addr_reg[14:0], lane_s2[0]};
                LW_TWO: addr_reg <= {addr_reg[13:0], lane_s2[1:0]};
                LW_FOUR: addr_reg <= {addr_reg[11:0], lane_s2[3:0]};
              endcase
            end
          end
          state_reg <= pre_done ? ST_DATA : ST_PRE;
        end
        ST_DATA: state_reg <= (beat && end_reg) ? ST_HIZ : ST_DATA;
        ST_HIZ: state_reg <= ST_HIZ;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    cur_byte = (beat_reg == 3'h0) ? mem_dout : byte_reg;
    unique case (out_w_reg)
      LW_TWO: beat_mask = 3'h3;
      LW_FOUR: beat_mask = 3'h1;
      default: beat_mask = 3'h7;
    endcase
  end

  snd_buf_mem u_mem (
    .clk(clk),
    .wr_en(load_we),
    .wr_addr(load_addr),
    .wr_data(load_data),
    .rd_addr(rd_addr_reg),
    .rd_data(mem_dout)
  );

  // read data path; the memory has a full half clock period to settle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_addr_reg <= 12'h0;
      byte_reg <= 8'h0;
      beat_reg <= 3'h0;
      end_reg <= 1'b0;
      lane_out_reg <= 4'h0;
      lane_oe_reg <= 4'h0;
      page_next_reg <= 1'b0;
    end else begin
      page_next_reg <= 1'b0;
      if (state_reg != ST_DATA) begin
        lane_oe_reg <= 4'h0;
      end
      if (pre_done) begin
        rd_addr_reg <= buf_reg ? addr_reg[11:0] : 12'h0;
        beat_reg <= 3'h0;
        end_reg <= 1'b0;
      end else if (beat) begin
        if (end_reg) begin
          lane_oe_reg <= 4'h0;
        end else begin
          unique case (out_w_reg)
            LW_TWO: begin
              lane_out_reg <= {2'b00, cur_byte[7:6]};
              lane_oe_reg <= 4'h3;
              byte_reg <= {cur_byte[5:0], 2'b00};
            end
            LW_FOUR: begin
              lane_out_reg <= cur_byte[7:4];
              lane_oe_reg <= 4'hF;
              byte_reg <= {cur_byte[3:0], 4'h0};
            end
            default: begin
              lane_out_reg <= {2'b00, cur_byte[7], 1'b0};
              lane_oe_reg <= 4'h2;
              byte_reg <= {cur_byte[6:0], 1'b0};
            end
          endcase
          beat_reg <= (beat_reg + 3'h1) & beat_mask;
          if (beat_reg == beat_mask) begin
            if (rd_addr_reg == `SND_BUF_LAST) begin
              if (buf_reg) begin
                end_reg <= 1'b1;
              end else begin
                rd_addr_reg <= 12'h0;
                page_next_reg <= 1'b1;
              end
            end else begin
              rd_addr_reg <= rd_addr_reg + 12'h1;
            end
          end
        end
      end
    end
  end

  assign lane_out = lane_out_reg;
  assign lane_oe = lane_oe_reg;
  assign page_next = page_next_reg;

  a_quad_gate_qe: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (cmd_done && quad_cmd && !four_lane_enable) |=> (state_reg == ST_HIZ) ##1 (lane_oe_reg == 4'h0))
    else $error("quad read taken without four_lane_enable");
  a_quad_gate_prot: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (cmd_done && quad_cmd && prot_mode) |=> (state_reg == ST_HIZ))
    else $error("quad read taken in protection mode");
  a_reject_float: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (state_reg == ST_HIZ) [*2] |-> (lane_oe_reg == 4'h0))
    else $error("lanes driven after rejection or buffer end");
  a_buf_start_col: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (pre_done && buf_reg) |=> (rd_addr_reg == $past(addr_reg[11:0])))
    else $error("buffer read did not start at column");
  a_cont_start_zero: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (pre_done && !buf_reg) |=> (rd_addr_reg == 12'h0) && (beat_reg == 3'h0))
    else $error("continuous read did not start at byte zero");
  a_addr_step_one: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (beat && !end_reg && beat_reg == beat_mask && rd_addr_reg != `SND_BUF_LAST)
    |=> (rd_addr_reg == $past(rd_addr_reg) + 12'h1))
    else $error("address did not step after byte");
  a_cont_page_wrap: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (beat && !end_reg && beat_reg == beat_mask && rd_addr_reg == `SND_BUF_LAST && !buf_reg)
    |=> (rd_addr_reg == 12'h0) && page_next_reg ##1 !page_next_reg)
    else $error("continuous read did not wrap to next page");
  a_buf_end_float: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (beat && end_reg) |=> (lane_oe_reg == 4'h0) && (state_reg == ST_HIZ))
    else $error("lanes still driven after final byte");
  a_dtr_rise_beat: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (state_reg == ST_DATA && dtr_reg && sclk_rise && !end_reg)
    |=> (beat_reg == (($past(beat_reg) + 3'h1) & $past(beat_mask))))
    else $error("double-rate read missed a rising edge");
  a_lane_width: assert property (@(posedge clk) disable iff (sys_rst || cs_hi)
    (state_reg == ST_DATA && lane_oe_reg != 4'h0)
    |-> (lane_oe_reg == ((out_w_reg == LW_FOUR) ? 4'hF : (out_w_reg == LW_TWO) ? 4'h3 : 4'h2)))
    else $error("wrong lanes driven for read width");
endmodule : snd_read_seq

/* File: snd_host_model.sv */
`timescale 1ns/1ps
module snd_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe
);
  logic host_oe = 1'b0;
  logic [3:0] host_val = 4'h0;
  logic [7:0] rx_data[$];
  logic [3:0] rx_oe[$];

  // a released lane shows the inverse of its last value, never a stale copy
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = lane_oe[i] ? lane_out[i] : (host_oe ? host_val[i] : ~host_val[i]);
    end
  end

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end

  task automatic xfer(input logic [7:0] code, input int pre, input int aw, input int ow,
    input bit dtr, input logic [15:0] col, input int nbytes);
    logic [15:0] c;
    logic [7:0] acc;
    logic [3:0] oes;
    int nb;
    c = col;
    acc = 8'h00;
    oes = 4'h0;
    nb = 0;
    rx_data.delete();
    rx_oe.delete();
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    host_oe = 1'b1;
    for (int i = 0; i < 8 + pre; i++) begin
      if (i < 8) begin
        host_val = {3'h0, code[7 - i]};
      end else begin
        host_val = (aw == 4) ? c[15:12] : (aw == 2) ? {2'h0, c[15:14]} : {3'h0, c[15]};
        c = c << aw;
      end
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    host_oe = 1'b0;
    // sample just before the next output edge, where the lanes have settled
    for (int s = 0; s < nbytes * 8 / ow; s++) begin
      if (!dtr) begin
        #40 sclk = 1'b1;
      end
      #40;
      // read the resolved bus, so an undriven lane shows its released level
      acc = (ow == 4) ? {acc[3:0], lane_in} :
        (ow == 2) ? {acc[5:0], lane_in[1:0]} : {acc[6:0], lane_in[1]};
      oes = oes | lane_oe;
      nb = nb + ow;
      if (nb == 8) begin
        rx_data.push_back(acc);
        rx_oe.push_back(oes);
        oes = 4'h0;
        nb = 0;
      end
      sclk = ~sclk;
    end
    #40 cs_n = 1'b1;
    sclk = 1'b0;
    #40;
  endtask : xfer
endmodule : snd_host_model

/* File: snd_read_seq_tb.sv */
`timescale 1ns/1ps
`include "snd_consts.svh"
module snd_read_seq_tb;
  localparam int BUF_N = `SND_BUF_BYTES;
  localparam int LIMIT = 60000;
  logic clk;
  logic sys_rst;
  logic sclk;
  logic cs_n;
  logic [3:0] lane_in;
  logic [3:0] lane_out;
  logic [3:0] lane_oe;
  logic four_lane_enable;
  logic prot_mode;
  logic buf_mode;
  logic load_we;
  logic [11:0] load_addr;
  logic [7:0] load_data;
  logic page_next;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int pn_count = 0;

  snd_read_seq dut_u (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
    .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe),
    .four_lane_enable(four_lane_enable), .prot_mode(prot_mode), .buf_mode(buf_mode),
    .load_we(load_we), .load_addr(load_addr), .load_data(load_data), .page_next(page_next));
  snd_host_model host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .lane_in(lane_in),
    .lane_out(lane_out), .lane_oe(lane_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (page_next === 1'b1) begin
      pn_count = pn_count + 1;
    end
    if (cyc == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  function automatic logic [7:0] pat(input int a);
    return 8'(a * 37 + (a >> 8));
  endfunction : pat

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic rd(input logic [7:0] code, input int pre, input int aw, input int ow,
    input bit dtr, input bit bm, input int col, input int n, input int nv);
    int a;
    logic [3:0] m;
    bit ok;
    @(posedge clk);
    #1;
    buf_mode = bm;
    m = (ow == 4) ? 4'hF : (ow == 2) ? 4'h3 : 4'h2;
    host_u.xfer(code, pre, aw, ow, dtr, col[15:0], n);
    for (int k = 0; k < n; k++) begin
      a = ((bm ? col : 0) + k) % BUF_N;
      ok = (k < nv) ? (host_u.rx_data[k] === pat(a) && host_u.rx_oe[k] === m) :
        (host_u.rx_oe[k] === 4'h0);
      cmp_count++;
      if (!ok) begin
        fail_count++;
        $display("[ERR] %0t code %h byte %0d got %h oe %h", $time, code, k,
          host_u.rx_data[k], host_u.rx_oe[k]);
      end
    end
  endtask : rd

  task automatic fill();
    for (int a = 0; a < BUF_N; a++) begin
      @(posedge clk);
      #1;
      load_we = 1'b1;
      load_addr = a[11:0];
      load_data = pat(a);
    end
    @(posedge clk);
    #1;
    load_we = 1'b0;
  endtask : fill

  task automatic t_single();
    rd(`SND_CMD_DTR, 16 + 8, 1, 1, 1, 1, 5, 3, 3);
    rd(`SND_CMD_DTR, 16 + 16, 1, 1, 1, 0, 9, 3, 3);
    rd(`SND_CMD_DTR4, 16 + 24, 1, 1, 1, 1, 700, 2, 2);
    rd(`SND_CMD_DTR4, 16 + 40, 1, 1, 1, 0, 700, 2, 2);
  endtask : t_single

  task automatic t_io();
    rd(`SND_CMD_DIO4, `SND_PRE_DIO4_B1, 2, 2, 0, 1, 300, 2, 2);
    rd(`SND_CMD_DIO4, `SND_PRE_DIO4_B0, 2, 2, 0, 0, 300, 2, 2);
    rd(`SND_CMD_QIO, `SND_PRE_QIO_B1, 4, 4, 0, 1, 291, 3, 3);
    rd(`SND_CMD_QIO, `SND_PRE_QIO_B0, 4, 4, 0, 0, 291, 3, 3);
    rd(`SND_CMD_QIO4, `SND_PRE_QIO4_B1, 4, 4, 0, 1, 2000, 2, 2);
    rd(`SND_CMD_QIO4, 14, 4, 4, 0, 0, 2000, 2, 2);
  endtask : t_io

  task automatic t_wide_end();
    rd(`SND_CMD_DTR_DUAL, 24, 1, 2, 1, 1, 40, 3, 3);
    rd(`SND_CMD_DTR_QUAD, 24, 1, 4, 1, 1, 77, 3, 3);
    rd(`SND_CMD_DTR_DUAL, 24, 1, 2, 1, 1, 2110, 4, 2);
    rd(`SND_CMD_QIO, 8, 4, 4, 0, 1, 2111, 3, 1);
  endtask : t_wide_end

  task automatic t_reject();
    // pass 0 lacks the quad enable, pass 1 has protection mode on
    for (int s = 0; s < 2; s++) begin
      four_lane_enable = s[0];
      prot_mode = s[0];
      rd(`SND_CMD_QIO, 8, 4, 4, 0, 1, 10, 2, 0);
      rd(`SND_CMD_QIO4, 14, 4, 4, 0, 1, 10, 2, 0);
      rd(`SND_CMD_DTR_QUAD, 24, 1, 4, 1, 1, 10, 2, 0);
    end
    rd(8'h5A, 24, 1, 1, 1, 1, 10, 2, 0);
    rd(`SND_CMD_DTR_DUAL, 24, 1, 2, 1, 1, 10, 2, 2);
    prot_mode = 1'b0;
  endtask : t_reject

  task automatic t_wrap();
    pn_count = 0;
    rd(`SND_CMD_DTR_QUAD, 32, 1, 4, 1, 0, 0, BUF_N + 2, BUF_N + 2);
    cmp_count++;
    if (pn_count != 1) begin
      fail_count++;
      $display("[ERR] %0t next page pulses %0d", $time, pn_count);
    end
  endtask : t_wrap

  initial begin
    sys_rst = 1'b1;
    four_lane_enable = 1'b1;
    prot_mode = 1'b0;
    buf_mode = 1'b1;
    load_we = 1'b0;
    load_addr = 12'h000;
    load_data = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    cmp_count++;
    if (lane_oe !== 4'h0 || page_next !== 1'b0) begin
      fail_count++;
      $display("[ERR] %0t outputs active after reset", $time);
    end
    fill();
    t_single();
    t_io();
    t_wide_end();
    t_reject();
    four_lane_enable = 1'b1;
    t_wrap();
    conclude();
  end
endmodule : snd_read_seq_tb
